// [shared/dfs_map.svh]
`ifndef DFS_MAP_SVH
`define DFS_MAP_SVH

// ---------------------------------------------------------------
// Storage geometry
// ---------------------------------------------------------------
`define DFS_DEPTH          16
`define DFS_DEPTH_CNT      5'h10
`define DFS_AE_OFFSET      5'h04

// ---------------------------------------------------------------
// Register offsets (byte addresses)
// ---------------------------------------------------------------
`define DFS_CTRL_OFF       12'h000
`define DFS_STAT_OFF       12'h004

// ---------------------------------------------------------------
// Control fields and reset value
// ---------------------------------------------------------------
`define DFS_CTRL_FALL_THROUGH_MODE      0
`define DFS_CTRL_BM        1
`define DFS_CTRL_BYTE      2
`define DFS_CTRL_BE        3
`define DFS_CTRL_RST       4'h0

// ---------------------------------------------------------------
// Status fields
// ---------------------------------------------------------------
`define DFS_STAT_F1_LVL    0
`define DFS_STAT_F2_LVL    8
`define DFS_STAT_FLAGS_A   16
`define DFS_STAT_FLAGS_B   20

`endif

// [shared/dfs_pkg.sv]
`include "dfs_map.svh"

package dfs_pkg;

	typedef logic [4:0]                    dfs_ptr_t;
	typedef logic [35:0]                   dfs_word_t;
	typedef logic [`DFS_DEPTH-1:0][35:0]   dfs_mem_t;

	// One port's request pins
	typedef struct packed {
		logic      chip_select_n;
		logic      dir_select;
		logic      mailbox_select;
		dfs_word_t data;
	} dfs_port_req_s;

	// One port's status flags
	typedef struct packed {
		logic almost_empty_n;
		logic input_ready_full_n;
		logic output_ready_empty_n;
	} dfs_flags_s;

	typedef struct packed {
		logic [3:0] ctrl;
		dfs_mem_t   mem1;
		dfs_mem_t   mem2;
		dfs_ptr_t   f1_wptr;
		dfs_ptr_t   f1_rptr;
		dfs_ptr_t   f2_wptr;
		dfs_ptr_t   f2_rptr;
		dfs_word_t  f1_head;
		logic       f1_head_vld;
		dfs_word_t  f2_head;
		logic       f2_head_vld;
		logic [1:0] b_rd_lane;
		logic [1:0] b_wr_lane;
		dfs_word_t  f2_asm;
		dfs_flags_s flags_a;
		dfs_flags_s flags_b;
		dfs_word_t  data_a;
		dfs_word_t  data_b;
		logic       pready;
		logic       pslverr;
		logic [31:0] prdata;
	} dfs_state_s;

endpackage : dfs_pkg

// [logic/dfs_flag_sync.sv]
`timescale 1ns/10ps

// Notes on behaviour
// [R1] Fall-through: word written to empty FIFO1 reaches port B output within three clocks.
// [R2] Port B output-ready for FIFO1 drops only on the last piece read.
// [R3] Standard: port B empty flag rises the clock after a write to empty FIFO1.
// [R4] Standard: port B empty flag falls only on the last piece read emptying FIFO1.
// [R5] Fall-through: word written to empty FIFO2 reaches port A output within three clocks.
// [R6] Port A flags for FIFO2 are timed from the last port B piece write.
// [R7] Standard: port A empty flag rises the clock after a long word enters FIFO2.
// [R8] Fall-through: port A input-ready rises the clock after a read frees FIFO1.
// [R9] Standard: FIFO1 space counts as freed only on the last port B piece read; fall-through frees it when a word loads into the port B head.
// [R10] Standard: port A full flag rises the clock after a read frees FIFO1.
// [R11] Fall-through: port B input-ready rises the clock after a read frees FIFO2.
// [R12] Port B input-ready falls only on the last piece write filling FIFO2.
// [R13] Standard: port B full flag rises the clock after a read frees FIFO2.
// [R14] Port B full flag falls only on the last piece write filling FIFO2.
// [R15] Port B almost-empty rises the clock after writes leave the almost-empty range.
// [R16] Port B almost-empty falls only on the last piece read from FIFO1.
// [R17] Port B reads FIFO1 with select low, direction high, mailbox low.
// [R18] Bus match and size stay static while operating; endian chosen before use.
// [R19] Pointer events between the two port sides pass a synchroniser before flags.
// [R20] Full or input-ready falls on the filling write; writes are ignored while low.
module dfs_flag_sync
	import dfs_pkg::*;
(
	// APB clock and reset
	input  wire logic          pclk,
	input  wire logic          presetn,
	// APB slave
	input  wire logic          psel,
	input  wire logic          penable,
	input  wire logic          pwrite,
	input  wire logic [11:0]   paddr,
	input  wire logic [31:0]   pwdata,
	output logic               pready,
	output logic [31:0]        prdata,
	output logic               pslverr,
	// Port A
	input  wire dfs_port_req_s porta_req,
	output dfs_word_t          porta_data_out,
	output dfs_flags_s         porta_flags,
	// Port B
	input  wire dfs_port_req_s portb_req,
	output dfs_word_t          portb_data_out,
	output dfs_flags_s         portb_flags
);

	// ---------------------------------------------------------------
	// Piece helpers for port B sizing
	// ---------------------------------------------------------------
	function automatic dfs_word_t get_piece(dfs_word_t w, logic bm, logic byt, logic [1:0] p);
		dfs_word_t r;
		r = w;
		if (bm && byt) begin
			case (p)
				2'h0: r = {27'h0, w[8:0]};
				2'h1: r = {27'h0, w[17:9]};
				2'h2: r = {27'h0, w[26:18]};
				default: r = {27'h0, w[35:27]};
			endcase
		end else if (bm) begin
			r = p[0] ? {18'h0, w[35:18]} : {18'h0, w[17:0]};
		end
		return r;
	endfunction : get_piece

	function automatic dfs_word_t put_piece(dfs_word_t w, dfs_word_t d, logic bm, logic byt, logic [1:0] p);
		dfs_word_t r;
		r = d;
		if (bm && byt) begin
			r = w;
			case (p)
				2'h0: r[8:0] = d[8:0];
				2'h1: r[17:9] = d[8:0];
				2'h2: r[26:18] = d[8:0];
				default: r[35:27] = d[8:0];
			endcase
		end else if (bm) begin
			r = w;
			if (p[0]) begin
				r[35:18] = d[17:0];
			end else begin
				r[17:0] = d[17:0];
			end
		end
		return r;
	endfunction : put_piece

	// ---------------------------------------------------------------
	// State
	// ---------------------------------------------------------------
	dfs_state_s st_reg;
	dfs_state_s st_next;

	logic       fall_through_mode;
	logic       bm;
	logic       byt;
	logic       be;
	logic [1:0] lanes_m1;
	logic [1:0] rd_piece;
	logic [1:0] wr_piece;
	logic       a_wr;
	logic       a_rd;
	logic       b_wr;
	logic       b_rd;
	logic       b_rd_last;
	logic       b_wr_last;
	logic       apb_setup;
	logic       apb_write;
	logic [31:0] stat_word;

	assign fall_through_mode      = st_reg.ctrl[`DFS_CTRL_FALL_THROUGH_MODE];
	assign bm        = st_reg.ctrl[`DFS_CTRL_BM];
	assign byt       = st_reg.ctrl[`DFS_CTRL_BYTE];
	assign be        = st_reg.ctrl[`DFS_CTRL_BE];
	assign lanes_m1  = bm ? (byt ? 2'h3 : 2'h1) : 2'h0;            // see [R18]
	assign rd_piece  = be ? 2'(lanes_m1 - st_reg.b_rd_lane) : st_reg.b_rd_lane;
	assign wr_piece  = be ? 2'(lanes_m1 - st_reg.b_wr_lane) : st_reg.b_wr_lane;
	assign b_rd_last = (st_reg.b_rd_lane == lanes_m1);
	assign b_wr_last = (st_reg.b_wr_lane == lanes_m1);

	// ---------------------------------------------------------------
	// Port decode
	// ---------------------------------------------------------------
	assign a_wr = !porta_req.chip_select_n && porta_req.dir_select && !porta_req.mailbox_select
		&& st_reg.flags_a.input_ready_full_n;                      // see [R20]
	assign a_rd = !porta_req.chip_select_n && !porta_req.dir_select && !porta_req.mailbox_select
		&& st_reg.flags_a.output_ready_empty_n;
	assign b_rd = !portb_req.chip_select_n && portb_req.dir_select && !portb_req.mailbox_select
		&& st_reg.flags_b.output_ready_empty_n;                    // see [R17]
	assign b_wr = !portb_req.chip_select_n && !portb_req.dir_select && !portb_req.mailbox_select
		&& st_reg.flags_b.input_ready_full_n;                      // see [R20]

	assign apb_setup = psel && !penable;
	assign apb_write = psel && penable && st_reg.pready && pwrite;

	always_comb begin
		stat_word = 32'h0;
		stat_word[`DFS_STAT_F1_LVL +: 5]  = 5'(st_reg.f1_wptr - st_reg.f1_rptr);
		stat_word[`DFS_STAT_F2_LVL +: 5]  = 5'(st_reg.f2_wptr - st_reg.f2_rptr);
		stat_word[`DFS_STAT_FLAGS_A +: 3] = st_reg.flags_a;
		stat_word[`DFS_STAT_FLAGS_B +: 3] = st_reg.flags_b;
	end

	// ---------------------------------------------------------------
	// Next state
	// ---------------------------------------------------------------
	always_comb begin
		st_next = st_reg;

		// FIFO1 write from port A
		if (a_wr) begin
			st_next.mem1[st_reg.f1_wptr[3:0]] = porta_req.data;
			st_next.f1_wptr = 5'(st_reg.f1_wptr + 5'h1);
		end

		// FIFO1 read on port B, piece by piece
		if (fall_through_mode) begin
			if (b_rd) begin
				if (b_rd_last) begin
					st_next.f1_head_vld = 1'b0;                    // see [R2]
					st_next.b_rd_lane = 2'h0;
				end else begin
					st_next.b_rd_lane = 2'(st_reg.b_rd_lane + 2'h1);
				end
			end
			// Same-clock pointers: the write is seen one edge later
			if (!st_next.f1_head_vld && (st_reg.f1_wptr != st_reg.f1_rptr)) begin // see [R19]
				st_next.f1_head = st_reg.mem1[st_reg.f1_rptr[3:0]];  // see [R1]
				st_next.f1_head_vld = 1'b1;
				st_next.f1_rptr = 5'(st_reg.f1_rptr + 5'h1);
			end
			st_next.data_b = get_piece(st_next.f1_head, bm, byt,
				be ? 2'(lanes_m1 - st_next.b_rd_lane) : st_next.b_rd_lane);
		end else if (b_rd) begin
			st_next.data_b = get_piece(st_reg.mem1[st_reg.f1_rptr[3:0]], bm, byt, rd_piece);
			if (b_rd_last) begin
				st_next.f1_rptr = 5'(st_reg.f1_rptr + 5'h1);      // see [R9]
				st_next.b_rd_lane = 2'h0;
			end else begin
				st_next.b_rd_lane = 2'(st_reg.b_rd_lane + 2'h1);
			end
		end

		// FIFO2 write from port B, assembled into long words
		if (b_wr) begin
			st_next.f2_asm = put_piece(st_reg.f2_asm, portb_req.data, bm, byt, wr_piece);
			if (b_wr_last) begin
				st_next.mem2[st_reg.f2_wptr[3:0]] = st_next.f2_asm; // see [R6]
				st_next.f2_wptr = 5'(st_reg.f2_wptr + 5'h1);
				st_next.f2_asm = 36'h0;
				st_next.b_wr_lane = 2'h0;
			end else begin
				st_next.b_wr_lane = 2'(st_reg.b_wr_lane + 2'h1);
			end
		end

		// FIFO2 read on port A
		if (fall_through_mode) begin
			if (a_rd) begin
				st_next.f2_head_vld = 1'b0;
			end
			if (!st_next.f2_head_vld && (st_reg.f2_wptr != st_reg.f2_rptr)) begin // see [R19]
				st_next.f2_head = st_reg.mem2[st_reg.f2_rptr[3:0]];  // see [R5]
				st_next.f2_head_vld = 1'b1;
				st_next.f2_rptr = 5'(st_reg.f2_rptr + 5'h1);
			end
			st_next.data_a = st_next.f2_head;
		end else if (a_rd) begin
			st_next.data_a = st_reg.mem2[st_reg.f2_rptr[3:0]];
			st_next.f2_rptr = 5'(st_reg.f2_rptr + 5'h1);
		end

		// Output-ready or empty flags
		st_next.flags_b.output_ready_empty_n = fall_through_mode ? st_next.f1_head_vld
			: (st_reg.f1_wptr != st_next.f1_rptr);                 // see [R3] see [R4]
		st_next.flags_a.output_ready_empty_n = fall_through_mode ? st_next.f2_head_vld
			: (st_reg.f2_wptr != st_next.f2_rptr);                 // see [R7]

		// Input-ready or full flags: fill seen at once, freeing one edge later
		st_next.flags_a.input_ready_full_n =
			(5'(st_next.f1_wptr - st_reg.f1_rptr) != `DFS_DEPTH_CNT); // see [R8] see [R10] see [R20]
		st_next.flags_b.input_ready_full_n =
			(5'(st_next.f2_wptr - st_reg.f2_rptr) != `DFS_DEPTH_CNT); // see [R11] see [R12] see [R13] see [R14]

		// Almost-empty flags
		st_next.flags_b.almost_empty_n =
			(5'(st_reg.f1_wptr - st_next.f1_rptr) > `DFS_AE_OFFSET); // see [R15] see [R16]
		st_next.flags_a.almost_empty_n =
			(5'(st_reg.f2_wptr - st_next.f2_rptr) > `DFS_AE_OFFSET);

		// APB slave: answer registered in the setup cycle
		st_next.pready = apb_setup;
		if (apb_setup) begin
			st_next.pslverr = 1'b0;
			st_next.prdata = 32'h0;
			case (paddr)
				`DFS_CTRL_OFF: st_next.prdata = {28'h0, st_reg.ctrl};
				`DFS_STAT_OFF: st_next.prdata = stat_word;
				default: st_next.pslverr = 1'b1;
			endcase
		end
		if (apb_write && (paddr == `DFS_CTRL_OFF)) begin
			st_next.ctrl = pwdata[3:0];
		end
	end

	// ---------------------------------------------------------------
	// State register
	// ---------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_reg <= '0;
			st_reg.ctrl <= `DFS_CTRL_RST;
			st_reg.flags_a.input_ready_full_n <= 1'b1;
			st_reg.flags_b.input_ready_full_n <= 1'b1;
		end else begin
			st_reg <= st_next;
		end
	end

	assign pready         = st_reg.pready;
	assign prdata         = st_reg.prdata;
	assign pslverr        = st_reg.pslverr;
	assign porta_data_out = st_reg.data_a;
	assign porta_flags    = st_reg.flags_a;
	assign portb_data_out = st_reg.data_b;
	assign portb_flags    = st_reg.flags_b;

endmodule : dfs_flag_sync

// [sim/dfs_flag_sync_monitor.sv]
`timescale 1ns/10ps
module dfs_flag_sync_monitor
	import dfs_pkg::*;
(
	// APB
	input wire logic          pclk,
	input wire logic          presetn,
	input wire logic          psel,
	input wire logic          penable,
	input wire logic          pwrite,
	input wire logic [11:0]   paddr,
	input wire logic [31:0]   pwdata,
	input wire logic          pready,
	// Ports
	input wire dfs_port_req_s porta_req,
	input wire dfs_flags_s    porta_flags,
	input wire dfs_port_req_s portb_req,
	input wire dfs_flags_s    portb_flags
);
	logic       a_wr, a_rd, b_wr, b_rd, lw, ao, ai, ba, bi, bo;
	logic [3:0] ctl_reg;

	function automatic logic go(dfs_port_req_s r, logic d, logic f);
		return !r.chip_select_n && r.dir_select == d && !r.mailbox_select && f;
	endfunction : go

	assign {ao, ai, ba, bi, bo} = {porta_flags.output_ready_empty_n, porta_flags.input_ready_full_n, portb_flags};
	assign a_wr = go(porta_req, 1'b1, ai);
	assign a_rd = go(porta_req, 1'b0, ao);
	assign b_rd = go(portb_req, 1'b1, bo);
	assign b_wr = go(portb_req, 1'b0, bi);
	assign lw   = !ctl_reg[1];

	// Shadow of the mode bits
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			ctl_reg <= 4'h0;
		else if (psel && penable && pready && pwrite && paddr == 12'h000)
			ctl_reg <= pwdata[3:0];
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_b_ready_rise: assert property (a_wr && !bo |-> ##[1:2] bo)
		else $error("port B ready late");
	a_a_ready_rise: assert property (lw && b_wr && !ao |-> ##[1:2] ao)
		else $error("port A ready late");
	a_a_space_back: assert property (lw && b_rd && !ai |-> ##[1:2] ai)
		else $error("port A space late");
	a_b_space_back: assert property (a_rd && !bi |-> ##[1:2] bi)
		else $error("port B space late");
	a_b_ready_hold: assert property (bo && !b_rd |=> bo)
		else $error("port B ready dropped");
	a_a_full_hold: assert property (!ai && !b_rd && !$past(b_rd) |=> !ai)
		else $error("port A full released");
	a_a_full_fall: assert property ($fell(ai) |-> $past(a_wr))
		else $error("port A full without write");
	a_b_almost_rise: assert property ($rose(ba) |-> $past(a_wr) || $past(a_wr, 2))
		else $error("almost empty rose alone");
	a_b_almost_fall: assert property (!ctl_reg[0] && $fell(ba) |-> $past(b_rd))
		else $error("almost empty fell alone");
	a_apb_one_wait: assert property (psel && !penable |=> pready)
		else $error("apb answer late");

	c_a_full: cover property (!ai);
	c_b_full: cover property (!bi);
	c_b_first: cover property (a_wr && !bo);
endmodule : dfs_flag_sync_monitor

bind dfs_flag_sync dfs_flag_sync_monitor u_mon (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
	.pready, .porta_req, .porta_flags, .portb_req, .portb_flags);

// [sim/dfs_port_host.sv]
`timescale 1ns/10ps
module dfs_port_host
	import dfs_pkg::*;
(
	// Clock
	input wire logic clk,
	// Pins toward the port
	output dfs_port_req_s req
);
	dfs_word_t last = '0;

	initial req = '{1'b1, 1'b0, 1'b0, '0};

	// Held across the edge that samples it
	task automatic put(input logic dir, input dfs_word_t d, input logic mbx = 1'b0);
		req <= '{1'b0, dir, mbx, d};
		last = d;
		@(posedge clk);
	endtask : put

	// Deselected bus shows the inverse of the last data
	task automatic idle(input int n);
		req <= '{1'b1, 1'b0, 1'b0, ~last};
		repeat (n) @(posedge clk);
	endtask : idle
endmodule : dfs_port_host

// [sim/test_dfs_flag_sync.sv]
`timescale 1ns/10ps
module test_dfs_flag_sync
	import dfs_pkg::*;
;
	logic          pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
	logic [11:0]   paddr;
	logic [31:0]   pwdata, prdata, rd;
	dfs_port_req_s porta_req, portb_req;
	dfs_word_t     porta_data_out, portb_data_out, w, w2;
	dfs_flags_s    porta_flags, portb_flags;
	int            n_mismatch = 0, samples_checked = 0, cyc = 0, n;
	dfs_word_t     q[$];

	dfs_port_host pa (.clk(pclk), .req(porta_req));
	dfs_port_host pb (.clk(pclk), .req(portb_req));
	dfs_flag_sync dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr,
		.porta_req, .porta_data_out, .porta_flags, .portb_req, .portb_data_out, .portb_flags);

	initial pclk = 1'b0;
	always #2 pclk = ~pclk;

	always @(posedge pclk) begin
		cyc++;
		if (cyc == 5000) begin
			n_mismatch++;
			end_sim();
		end
	end

	task automatic chk(input logic [35:0] seen, exp);
		samples_checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: got %h want %h", $time, seen, exp);
		end
	endtask : chk

	task automatic end_sim();
		$display("compares %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : end_sim

	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb

	function automatic logic [35:0] fl(dfs_flags_s f);
		return {33'h0, f};
	endfunction : fl

	// Piece i of a long word in port B order
	function automatic dfs_word_t piece(dfs_word_t v, int i, logic byt, logic be);
		int k;
		k = be ? (byt ? 3 : 1) - i : i;
		return byt ? {27'h0, v[k*9 +: 9]} : {18'h0, v[k*18 +: 18]};
	endfunction : piece

	initial begin
		presetn <= 1'b0;
		psel <= 1'b0;
		penable <= 1'b0;
		pwrite <= 1'b0;
		paddr <= '0;
		pwdata <= '0;
		void'($urandom(32'h7fdacb43));
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		chk(fl(porta_flags), 36'h2);
		chk(fl(portb_flags), 36'h2);
		apb(1'b0, 12'h000, 32'h0);
		chk({4'h0, rd}, 36'h0);
		apb(1'b0, 12'hff0, $urandom);
		chk({3'h0, er, rd}, 36'h100000000);
		$display("reset test done");
		for (int i = 0; i < 17; i++) begin
			w = {$urandom, 4'($urandom)};
			if (i < 16)
				q.push_back(w);
			pa.put(1'b1, w);
			if (i == 2)
				chk(fl(portb_flags), 36'h3);
		end
		pa.idle(2);
		chk(fl(porta_flags), 36'h0);
		chk(fl(portb_flags), 36'h7);
		// Status: FIFO1 level 16, port A flags 0, port B flags 7
		apb(1'b0, 12'h004, 32'h0);
		chk({4'h0, rd}, 36'h000700010);
		for (int i = 0; i < 16; i++) begin
			pb.put(1'b1, '0);
			if (i)
				chk(portb_data_out, q.pop_front());
			if (i == 2)
				chk(fl(porta_flags), 36'h2);
		end
		pb.idle(2);
		chk(portb_data_out, q.pop_front());
		chk(fl(portb_flags), 36'h2);
		$display("standard test done");
		apb(1'b1, 12'h000, 32'h1);
		w = {$urandom, 4'h9};
		// Mailbox-selected accesses must leave both FIFOs alone
		pa.put(1'b1, ~w, 1'b1);
		pa.idle(2);
		chk(fl(portb_flags), 36'h2);
		pa.put(1'b1, w);
		pa.idle(2);
		chk(portb_data_out, w);
		chk(fl(portb_flags), 36'h3);
		pb.put(1'b1, '0, 1'b1);
		pb.idle(1);
		chk(fl(portb_flags), 36'h3);
		pb.put(1'b1, '0);
		pb.put(1'b0, w, 1'b1);
		pb.put(1'b0, ~w);
		pb.idle(2);
		chk(fl(portb_flags), 36'h2);
		chk(porta_data_out, ~w);
		chk(fl(porta_flags), 36'h3);
		pa.put(1'b0, '0);
		pa.idle(1);
		chk(fl(porta_flags), 36'h2);
		$display("fall-through test done");
		for (int c = 0; c < 4; c++) begin
			apb(1'b1, 12'h000, {28'h0, c[1:0], 2'b10});
			n = c[0] ? 4 : 2;
			w = {$urandom, 4'($urandom)};
			w2 = {$urandom, 4'($urandom)};
			pa.put(1'b1, w);
			pa.idle(2);
			for (int i = 0; i < n; i++) begin
				pb.put(1'b1, '0);
				if (i)
					chk(portb_data_out, piece(w, i - 1, c[0], c[1]));
				if (i)
					chk(fl(portb_flags), 36'h3);
			end
			pb.idle(1);
			chk(portb_data_out, piece(w, n - 1, c[0], c[1]));
			chk(fl(portb_flags), 36'h2);
			for (int i = 0; i < n; i++) begin
				pb.put(1'b0, piece(w2, i, c[0], c[1]));
				if (i)
					chk(fl(porta_flags), 36'h2);
			end
			pb.idle(2);
			chk(fl(porta_flags), 36'h3);
			pa.put(1'b0, '0);
			pa.idle(1);
			chk(porta_data_out, w2);
		end
		$display("sizing test done");
		apb(1'b1, 12'h000, 32'h0);
		for (int i = 0; i < 16; i++)
			pb.put(1'b0, {$urandom, 4'h0});
		pb.idle(1);
		chk(fl(portb_flags), 36'h0);
		pa.put(1'b0, '0);
		pa.idle(2);
		chk(fl(portb_flags), 36'h2);
		$display("full test done");
		end_sim();
	end
endmodule : test_dfs_flag_sync
